// ### rtl/sps_ctrl.sv
// Contract
// - Five selectable power-save modes; blink mode after reset.
// - Blink mode toggles laser after idle timeout; a decode ends it.
// - Laser-off mode keeps motor spinning; button press restores scanning.
// - Laser-and-motor-off mode stops both; wake includes motor restart delay.
// - Dual mode one blinks, then stops laser and motor after thirty minutes.
// - Dual mode two turns laser off, then motor off after thirty minutes.
// - Short press advances tone, beeps, pauses, beeps twice more.
// - Long press enters laser-and-motor-off; button enters no other mode.
// - Any press during power save returns to normal scanning.
// - Eight tone settings: normal, six alternates and silent.
// - Power up: green on, one beep, red on for the beep.
// - Decode flashes red and beeps once when beeping is enabled.
// - Program mode entry and exit give three beeps; LEDs flash inside.
// - Optional three beeps on host communication timeout while scanning.
// - Config accepted: three beeps, pause, high tone then low tone.
// - Laser fault: green flashes and one error tone.
// - Motor fault: both LEDs flash and two error tones.
// - Electronics fault at power up: continuous error tone, LEDs dark.
// - Configuration storage fault at power up gives three beeps.
// - Green lit while laser active, held on during blinking.
// - Aux data accepted only when aux input enabled for slave format.
//
// Local design decisions: the address-and-strobe port and the register offsets.
`default_nettype none
module sps_ctrl #(
   parameter int unsigned TICK_CYC = sps_pkg::TICK_CYC
) (
   input  wire logic             clk_sys,
   input  wire logic             rstn,
   input  wire sps_pkg::sps_bus_s bus,
   output logic [31:0]           rdata,
   input  wire sps_pkg::sps_evt_s evt,
   input  wire logic             btn,
   input  wire logic             aux_rx_vld,
   input  wire logic [7:0]       aux_rx_byte,
   input  wire logic             aux_rts,
   output logic                  aux_cts,
   output sps_pkg::sps_ind_s     ind
);
   import sps_pkg::*;

   sps_st_s st_ff;
   sps_st_s nxt_st;

   // ---------------------------------------------------------------
   // Sequence launcher
   // ---------------------------------------------------------------
   function automatic sps_seq_s seq_go(input logic [2:0] n, input logic [1:0] g2,
                                       input logic tail, input logic [3:0] tn);
      sps_seq_s s;
      s.ph   = SQ_BEEP;
      s.n    = n;
      s.g2   = g2;
      s.tail = tail;
      s.cont = 1'b0;
      s.tone = tn;
      s.ms   = 10'h000;
      return s;
   endfunction

   logic        tick;
   logic        press;
   logic        release_ev;
   logic        aux_ok;
   logic        in_ps;
   logic [9:0]  sq_dur;
   logic [2:0]  mode;
   logic [3:0]  utone;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb
   begin
      nxt_st     = st_ff;
      tick       = (st_ff.tick == 18'(TICK_CYC - 1));
      nxt_st.tick = tick ? 18'h00000 : st_ff.tick + 18'h00001;
      mode       = st_ff.ctrl[CT_MODE +: 3];
      utone      = {1'b0, st_ff.tone};
      in_ps      = (st_ff.ps != PS_RUN);
      press      = 1'b0;
      release_ev = 1'b0;
      aux_ok     = aux_rx_vld && aux_rts && st_ff.aux_cts;

      // Debounce: level must stay changed for a full window
      if (btn == st_ff.btn_st)
         nxt_st.deb = 5'h00;
      else if (tick)
      begin
         if (st_ff.deb == 5'(DEB_MS - 1))
         begin
            nxt_st.deb    = 5'h00;
            nxt_st.btn_st = btn;
            press         = btn;
            release_ev    = ~btn;
         end
         else
            nxt_st.deb = st_ff.deb + 5'h01;
      end

      // Bus writes
      if (bus.wr)
      begin
         case (bus.addr)
            REG_CTRL: nxt_st.ctrl     = bus.wdata[6:0];
            REG_TONE: nxt_st.tone     = bus.wdata[2:0];
            REG_IDLE: nxt_st.idle_lim = bus.wdata[23:0];
            default:  ;
         endcase
      end

      // Sequencer timing
      case (st_ff.seq.ph)
         SQ_GAP:   sq_dur = 10'(GAP_MS - 1);
         SQ_PAUSE: sq_dur = 10'(PAUSE_MS - 1);
         default:  sq_dur = 10'(BEEP_MS - 1);
      endcase
      if (tick && st_ff.seq.ph != SQ_IDLE)
      begin
         nxt_st.seq.ms = st_ff.seq.ms + 10'h001;
         if (st_ff.seq.ms == sq_dur)
         begin
            nxt_st.seq.ms = 10'h000;
            case (st_ff.seq.ph)
               SQ_BEEP:
                  if (st_ff.seq.cont)
                     nxt_st.seq.ph = SQ_BEEP;
                  else if (st_ff.seq.n > 3'h1)
                  begin
                     nxt_st.seq.ph = SQ_GAP;
                     nxt_st.seq.n  = st_ff.seq.n - 3'h1;
                  end
                  else if (st_ff.seq.g2 != 2'h0 || st_ff.seq.tail)
                     nxt_st.seq.ph = SQ_PAUSE;
                  else
                     nxt_st.seq.ph = SQ_IDLE;
               SQ_GAP:   nxt_st.seq.ph = SQ_BEEP;
               SQ_PAUSE:
                  if (st_ff.seq.tail)
                  begin
                     nxt_st.seq.ph   = SQ_HI;
                     nxt_st.seq.tail = 1'b0;
                  end
                  else
                  begin
                     nxt_st.seq.ph = SQ_BEEP;
                     nxt_st.seq.n  = {1'b0, st_ff.seq.g2};
                     nxt_st.seq.g2 = 2'h0;
                  end
               SQ_HI:    nxt_st.seq.ph = SQ_LO;
               default:  nxt_st.seq.ph = SQ_IDLE;
            endcase
         end
      end

      // Free-running flash and blink phases
      if (tick)
      begin
         nxt_st.pf_ms = st_ff.pf_ms + 8'h01;
         if (st_ff.pf_ms == 8'(PFLASH_MS - 1))
         begin
            nxt_st.pf_ms = 8'h00;
            nxt_st.pf    = ~st_ff.pf;
         end
         nxt_st.blink_ms = st_ff.blink_ms + 9'h001;
         if (st_ff.blink_ms == 9'(BLINK_MS - 1))
         begin
            nxt_st.blink_ms = 9'h000;
            nxt_st.blink    = ~st_ff.blink;
         end
         if (st_ff.red_ms != 7'h00)
            nxt_st.red_ms = st_ff.red_ms - 7'h01;
      end

      case (st_ff.sys)
         SYS_BOOT:
         begin
            // Power-up self-check result picks the first sequence
            if (evt.elec_flt)
            begin
               nxt_st.sys      = SYS_ELEC;
               nxt_st.seq      = seq_go(3'h1, 2'h0, 1'b0, TN_RAZZ);
               nxt_st.seq.cont = 1'b1;
            end
            else
            begin
               nxt_st.sys      = SYS_RUN;
               nxt_st.boot_red = 1'b1;
               if (evt.nv_flt)
                  nxt_st.seq = seq_go(3'h3, 2'h0, 1'b0, utone);
               else
                  nxt_st.seq = seq_go(3'h1, 2'h0, 1'b0, utone);
            end
         end
         SYS_RUN:
         begin
            if (st_ff.seq.ph == SQ_IDLE)
               nxt_st.boot_red = 1'b0;

            // Button press timing
            if (press)
            begin
               nxt_st.btn_ms   = 12'h000;
               nxt_st.btn_long = 1'b0;
               nxt_st.btn_wk   = in_ps;
               nxt_st.idle     = 24'h000000;
               if (st_ff.ps == PS_LMOFF)
               begin
                  nxt_st.ps   = PS_WAKE;
                  nxt_st.wake = 10'h000;
               end
               else if (in_ps && st_ff.ps != PS_WAKE)
                  nxt_st.ps = PS_RUN;
            end
            else if (st_ff.btn_st && tick && !st_ff.btn_long && !st_ff.btn_wk)
            begin
               nxt_st.btn_ms = st_ff.btn_ms + 12'h001;
               if (st_ff.btn_ms == 12'(LONG_MS - 1))
               begin
                  nxt_st.btn_long = 1'b1;
                  nxt_st.ps       = PS_LMOFF;
               end
            end
            if (release_ev && !st_ff.btn_long && !st_ff.btn_wk)
            begin
               nxt_st.tone = st_ff.tone + 3'h1;
               nxt_st.seq  = seq_go(3'h1, 2'h2, 1'b0, {1'b0, st_ff.tone + 3'h1});
            end

            // Inactivity and power-save progression
            if (st_ff.ps == PS_RUN && !press)
            begin
               if (evt.decode_ok || aux_ok)
                  nxt_st.idle = 24'h000000;
               else if (tick)
                  nxt_st.idle = st_ff.idle + 24'h000001;
               if (st_ff.idle_lim != 24'h000000 && st_ff.idle >= st_ff.idle_lim)
               begin
                  nxt_st.dual = 21'h000000;
                  nxt_st.idle = 24'h000000;
                  case (mode)
                     MODE_LOFF, MODE_DUAL2: nxt_st.ps = PS_LOFF;
                     MODE_LMOFF:            nxt_st.ps = PS_LMOFF;
                     default:               nxt_st.ps = PS_BLINK;
                  endcase
               end
            end
            else if (!press && tick)
            begin
               nxt_st.dual = st_ff.dual + 21'h000001;
               if (st_ff.dual == 21'(DUAL_MS - 1))
               begin
                  nxt_st.dual = 21'h000000;
                  if (st_ff.ps == PS_BLINK && mode == MODE_DUAL1)
                     nxt_st.ps = PS_LMOFF;
                  if (st_ff.ps == PS_LOFF && mode == MODE_DUAL2)
                     nxt_st.ps = PS_LMOFF;
               end
               if (st_ff.ps == PS_WAKE)
               begin
                  nxt_st.wake = st_ff.wake + 10'h001;
                  if (st_ff.wake == 10'(RESTART_MS - 1))
                     nxt_st.ps = PS_RUN;
               end
            end
            if (st_ff.ps == PS_BLINK && evt.decode_ok && !press)
               nxt_st.ps = PS_RUN;

            // Indicator events, later ones take the beeper over
            if (evt.decode_ok && (st_ff.ps == PS_RUN || st_ff.ps == PS_BLINK))
            begin
               nxt_st.red_ms = 7'(FLASH_MS);
               if (st_ff.ctrl[CT_BEEP])
                  nxt_st.seq = seq_go(3'h1, 2'h0, 1'b0, utone);
            end
            if (evt.comm_to && st_ff.ctrl[CT_COMM] && st_ff.ps == PS_RUN)
               nxt_st.seq = seq_go(3'h3, 2'h0, 1'b0, utone);
            if (evt.cfg_ok)
               nxt_st.seq = seq_go(3'h3, 2'h0, 1'b1, utone);
            nxt_st.prog_d = evt.prog_mode;
            if (evt.prog_mode != st_ff.prog_d)
               nxt_st.seq = seq_go(3'h3, 2'h0, 1'b0, utone);
            if (evt.laser_flt)
            begin
               nxt_st.lflt = 1'b1;
               nxt_st.seq  = seq_go(3'h1, 2'h0, 1'b0, TN_RAZZ);
            end
            if (evt.motor_flt)
            begin
               nxt_st.mflt = 1'b1;
               nxt_st.seq  = seq_go(3'h2, 2'h0, 1'b0, TN_RAZZ);
            end
         end
         SYS_ELEC: ;
         default: nxt_st.sys = SYS_BOOT;
      endcase

      // Auxiliary input: slave-formatted data only when enabled
      nxt_st.aux_cts = st_ff.ctrl[CT_AUXEN] && st_ff.ctrl[CT_AUXSL]
                       && st_ff.sys == SYS_RUN;
      if (bus.rd && bus.addr == REG_AUX)
         nxt_st.aux_vld = 1'b0;
      if (aux_ok)
      begin
         nxt_st.aux_byte = aux_rx_byte;
         nxt_st.aux_vld  = 1'b1;
      end

      // Read data stands only in the cycle after the strobe
      nxt_st.rdata = 32'h00000000;
      if (bus.rd)
      begin
         case (bus.addr)
            REG_CTRL: nxt_st.rdata = {25'h0000000, st_ff.ctrl};
            REG_TONE: nxt_st.rdata = {29'h00000000, st_ff.tone};
            REG_IDLE: nxt_st.rdata = {8'h00, st_ff.idle_lim};
            REG_STAT: nxt_st.rdata = {21'h000000, st_ff.mflt, st_ff.lflt, st_ff.prog_d,
                                      st_ff.ind.motor_on, st_ff.ind.laser_on,
                                      st_ff.ps, st_ff.sys, st_ff.btn_st};
            REG_AUX:  nxt_st.rdata = {23'h000000, st_ff.aux_vld, st_ff.aux_byte};
            default:  nxt_st.rdata = 32'h00000000;
         endcase
      end

      // ---------------------------------------------------------------
      // Indicator drive
      // ---------------------------------------------------------------
      // Outputs lag the state by one cycle so every pin leaves a flop
      nxt_st.ind.laser_on = st_ff.sys == SYS_RUN && (st_ff.ps == PS_RUN
                            || (st_ff.ps == PS_BLINK && st_ff.blink));
      nxt_st.ind.motor_on = st_ff.sys == SYS_RUN && st_ff.ps != PS_LMOFF;
      nxt_st.ind.led_green = st_ff.sys == SYS_RUN && (st_ff.ps == PS_RUN
                             || st_ff.ps == PS_BLINK);
      nxt_st.ind.led_red = st_ff.boot_red || st_ff.red_ms != 7'h00;
      if (st_ff.prog_d || st_ff.mflt)
      begin
         nxt_st.ind.led_green = st_ff.pf;
         nxt_st.ind.led_red   = st_ff.pf;
      end
      else if (st_ff.lflt)
         nxt_st.ind.led_green = st_ff.pf;
      if (st_ff.sys != SYS_RUN)
      begin
         nxt_st.ind.led_green = 1'b0;
         nxt_st.ind.led_red   = 1'b0;
      end
      nxt_st.ind.bp_tone = st_ff.seq.ph == SQ_HI ? TN_HIGH :
                           st_ff.seq.ph == SQ_LO ? TN_LOW : st_ff.seq.tone;
      // Silent setting keeps the timing but mutes the driver
      nxt_st.ind.bp_on = (st_ff.seq.ph == SQ_BEEP || st_ff.seq.ph == SQ_HI
                         || st_ff.seq.ph == SQ_LO)
                         && st_ff.seq.tone != {1'b0, TN_SILENT};
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         st_ff          <= '0;
         st_ff.sys      <= SYS_BOOT;
         st_ff.ps       <= PS_RUN;
         st_ff.seq.ph   <= SQ_IDLE;
         st_ff.ctrl     <= CTRL_RST;
         st_ff.tone     <= TONE_RST;
         st_ff.idle_lim <= IDLE_RST;
      end
      else
         st_ff <= nxt_st;
   end

   assign rdata   = st_ff.rdata;
   assign aux_cts = st_ff.aux_cts;
   assign ind     = st_ff.ind;

endmodule // sps_ctrl
`default_nettype wire

// ### rtl/sps_pkg.sv
`default_nettype none
package sps_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_MHZ    = 250;
   localparam int unsigned TICK_US    = 1000;
   localparam int unsigned TICK_CYC   = TICK_US * CLK_MHZ;
   localparam int unsigned DEB_MS     = 20;
   localparam int unsigned LONG_S     = 3;
   localparam int unsigned LONG_MS    = LONG_S * 1000;
   localparam int unsigned BEEP_MS    = 100;
   localparam int unsigned GAP_MS     = 100;
   localparam int unsigned PAUSE_MS   = 400;
   localparam int unsigned FLASH_MS   = 100;
   localparam int unsigned BLINK_MS   = 500;
   localparam int unsigned PFLASH_MS  = 250;
   localparam int unsigned RESTART_MS = 1000;
   localparam int unsigned DUAL_MIN   = 30;
   localparam int unsigned DUAL_MS    = DUAL_MIN * 60 * 1000;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [7:0]  REG_CTRL   = 8'h00;
   localparam logic [7:0]  REG_TONE   = 8'h04;
   localparam logic [7:0]  REG_IDLE   = 8'h08;
   localparam logic [7:0]  REG_STAT   = 8'h0c;
   localparam logic [7:0]  REG_AUX    = 8'h10;
   localparam int unsigned CT_MODE    = 0;
   localparam int unsigned CT_BEEP    = 3;
   localparam int unsigned CT_COMM    = 4;
   localparam int unsigned CT_AUXEN   = 5;
   localparam int unsigned CT_AUXSL   = 6;
   localparam logic [6:0]  CTRL_RST   = 7'h08;
   localparam logic [2:0]  TONE_RST   = 3'h0;
   localparam logic [23:0] IDLE_RST   = 24'h0927c0;

   // ---------------------------------------------------------------
   // Encodings
   // ---------------------------------------------------------------
   localparam logic [2:0]  MODE_BLINK = 3'h0;
   localparam logic [2:0]  MODE_LOFF  = 3'h1;
   localparam logic [2:0]  MODE_LMOFF = 3'h2;
   localparam logic [2:0]  MODE_DUAL1 = 3'h3;
   localparam logic [2:0]  MODE_DUAL2 = 3'h4;
   localparam logic [2:0]  TN_SILENT  = 3'h7;
   localparam logic [3:0]  TN_HIGH    = 4'h8;
   localparam logic [3:0]  TN_LOW     = 4'h9;
   localparam logic [3:0]  TN_RAZZ    = 4'ha;

   typedef enum logic [1:0] {SYS_BOOT, SYS_RUN, SYS_ELEC} sps_sys_e;
   typedef enum logic [2:0] {PS_RUN, PS_BLINK, PS_LOFF, PS_LMOFF, PS_WAKE} sps_ps_e;
   typedef enum logic [2:0] {SQ_IDLE, SQ_BEEP, SQ_GAP, SQ_PAUSE, SQ_HI, SQ_LO} sps_sq_e;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } sps_bus_s;

   typedef struct packed {
      logic decode_ok;
      logic prog_mode;
      logic comm_to;
      logic cfg_ok;
      logic laser_flt;
      logic motor_flt;
      logic elec_flt;
      logic nv_flt;
   } sps_evt_s;

   typedef struct packed {
      logic       laser_on;
      logic       motor_on;
      logic       led_red;
      logic       led_green;
      logic       bp_on;
      logic [3:0] bp_tone;
   } sps_ind_s;

   typedef struct packed {
      sps_sq_e    ph;
      logic [2:0] n;
      logic [1:0] g2;
      logic       tail;
      logic       cont;
      logic [3:0] tone;
      logic [9:0] ms;
   } sps_seq_s;

   typedef struct packed {
      sps_sys_e    sys;
      sps_ps_e     ps;
      sps_seq_s    seq;
      logic [6:0]  ctrl;
      logic [2:0]  tone;
      logic [23:0] idle_lim;
      logic [17:0] tick;
      logic [23:0] idle;
      logic [20:0] dual;
      logic [9:0]  wake;
      logic        btn_st;
      logic [4:0]  deb;
      logic [11:0] btn_ms;
      logic        btn_long;
      logic        btn_wk;
      logic [6:0]  red_ms;
      logic        boot_red;
      logic [8:0]  blink_ms;
      logic        blink;
      logic [7:0]  pf_ms;
      logic        pf;
      logic        prog_d;
      logic        lflt;
      logic        mflt;
      logic [7:0]  aux_byte;
      logic        aux_vld;
      logic [31:0] rdata;
      sps_ind_s    ind;
      logic        aux_cts;
   } sps_st_s;

endpackage
`default_nettype wire

// ### verif/sps_ctrl_assertions.sv
`default_nettype none
module sps_chk #(
   parameter int unsigned TICK_CYC = sps_pkg::TICK_CYC
) (
   input wire logic              clk_sys,
   input wire logic              rstn,
   input wire sps_pkg::sps_evt_s evt,
   input wire sps_pkg::sps_ind_s ind
);
   timeunit 1ns;
   timeprecision 1ps;
   import sps_pkg::*;

   logic        odd_ff;
   logic        first_ff;
   logic        elec_ff;
   logic [2:0]  el_ff;
   logic [31:0] up_ff;

   // --------
   // Helpers
   // --------
   // Program mode and latched faults change what the LEDs mean, so some checks stand down
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         odd_ff   <= 1'b0;
         first_ff <= 1'b1;
         elec_ff  <= 1'b0;
         el_ff    <= 3'h0;
         up_ff    <= 32'h0;
      end
      else
      begin
         odd_ff   <= odd_ff | evt.prog_mode | evt.laser_flt | evt.motor_flt;
         first_ff <= 1'b0;
         elec_ff  <= elec_ff | (first_ff & evt.elec_flt);
         el_ff    <= (elec_ff && el_ff != 3'h7) ? el_ff + 3'h1 : el_ff;
         up_ff    <= (up_ff != 32'hffffffff) ? up_ff + 32'h1 : up_ff;
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);

   // --------
   // Sequences
   // --------
   sequence s_red_held;
      ind.led_red [*8];
   endsequence
   sequence s_beep_held;
      ind.bp_on [*8];
   endsequence
   sequence s_dark_razz;
      !ind.led_red && !ind.led_green && ind.bp_on && ind.bp_tone == TN_RAZZ;
   endsequence

   // --------
   // Properties
   // --------
   a_silent_mute: assert property (
      ind.bp_tone == {1'b0, TN_SILENT} |-> !ind.bp_on) else $error("beeper on while silent");
   a_green_laser: assert property (
      ind.laser_on && !odd_ff |-> ind.led_green) else $error("laser on with green dark");
   a_laser_needs_motor: assert property (
      ind.laser_on && !odd_ff |-> ind.motor_on) else $error("laser on with motor stopped");
   a_decode_red_flash: assert property (
      evt.decode_ok && ind.laser_on && !odd_ff |-> ##2 s_red_held) else $error("no red flash");
   a_beep_length: assert property (
      $rose(ind.bp_on) |-> s_beep_held) else $error("beep cut short");
   a_elec_razz: assert property (
      el_ff == 3'h7 |-> s_dark_razz) else $error("electronics fault not signalled");
   a_motor_restart: assert property (
      $rose(ind.motor_on) && up_ff > 400 * TICK_CYC && !odd_ff |-> !ind.laser_on [*8])
      else $error("laser on before motor restart");
   a_laser_fault_razz: assert property (
      evt.laser_flt |-> ##[1:4] (ind.bp_on && ind.bp_tone == TN_RAZZ))
      else $error("no error tone on laser fault");
endmodule // sps_chk

bind sps_ctrl sps_chk #(.TICK_CYC(TICK_CYC)) u_chk (
   .clk_sys (clk_sys),
   .rstn    (rstn),
   .evt     (evt),
   .ind     (ind)
);
`default_nettype wire

// ### verif/sps_far.sv
`default_nettype none
module sps_far (
   input  wire logic       clk_sys,
   input  wire logic       aux_cts,
   output logic            btn,
   output logic            aux_rts,
   output logic            aux_rx_vld,
   output logic [7:0]      aux_rx_byte
);
   timeunit 1ns;
   timeprecision 1ps;

   // --------
   // Button and aux scanner
   // --------
   initial
   begin
      btn = 1'b0;
      aux_rts = 1'b1;
      aux_rx_vld = 1'b0;
      aux_rx_byte = 8'h00;
   end

   task automatic press(input int n);
      @(posedge clk_sys);
      btn <= 1'b1;
      repeat (n) @(posedge clk_sys);
      btn <= 1'b0;
   endtask

   // A rude send ignores the ready line, to see the byte refused
   task automatic send(input logic [7:0] b, input logic rude);
      @(posedge clk_sys);
      while (!rude && !aux_cts) @(posedge clk_sys);
      aux_rx_vld <= 1'b1;
      aux_rx_byte <= b;
      @(posedge clk_sys);
      aux_rx_vld <= 1'b0;
      aux_rx_byte <= ~b;
   endtask
endmodule // sps_far
`default_nettype wire

// ### verif/tb_sps_ctrl.sv
`default_nettype none
module tb_sps_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   import sps_pkg::*;

   logic        clk_sys;
   logic        rstn;
   sps_bus_s    bus;
   logic [31:0] rdata;
   sps_evt_s    evt;
   logic        btn;
   logic        aux_rts;
   logic        aux_rx_vld;
   logic [7:0]  aux_rx_byte;
   logic        aux_cts;
   sps_ind_s    ind;
   int          fails;
   int          n_checks;
   logic [2:0]  mo [5] = '{MODE_BLINK, MODE_LOFF, MODE_DUAL1, MODE_DUAL2, MODE_LMOFF};
   sps_ps_e     pe [5] = '{PS_BLINK, PS_LOFF, PS_BLINK, PS_LOFF, PS_LMOFF};

   // Short tick so every millisecond figure shrinks to ten clocks
   sps_ctrl #(.TICK_CYC(10)) u_dut (.clk_sys(clk_sys), .rstn(rstn), .bus(bus), .rdata(rdata),
      .evt(evt), .btn(btn), .aux_rx_vld(aux_rx_vld), .aux_rx_byte(aux_rx_byte),
      .aux_rts(aux_rts), .aux_cts(aux_cts), .ind(ind));
   sps_far u_far (.clk_sys(clk_sys), .aux_cts(aux_cts), .btn(btn), .aux_rts(aux_rts),
      .aux_rx_vld(aux_rx_vld), .aux_rx_byte(aux_rx_byte));

   // --------
   // Tasks
   // --------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      bus.wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      @(posedge clk_sys);
      bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      bus.rd <= 1'b0;
      #1;
      chk(rdata & m, e);
   endtask
   task automatic pulse(input logic [7:0] m);
      @(posedge clk_sys);
      evt <= evt | m;
      @(posedge clk_sys);
      evt <= evt & ~m;
   endtask
   task automatic beeps(input int n, input int e);
      logic p;
      int   c;
      p = ind.bp_on;
      c = 0;
      repeat (n)
      begin
         cyc(1);
         if (ind.bp_on && !p)
            c++;
         p = ind.bp_on;
      end
      chk(32'(c), 32'(e));
   endtask
   task automatic rst(input logic el, input logic nv);
      @(posedge clk_sys);
      rstn <= 1'b0;
      evt <= {6'h0, el, nv};
      repeat (10) @(posedge clk_sys);
      rstn <= 1'b1;
   endtask
   task automatic report_and_stop();
      if (fails == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // --------
   // Clock, watchdog, tests
   // --------
   initial
   begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   initial
   begin
      repeat (95000) @(posedge clk_sys);
      fails++;
      report_and_stop();
   end
   initial
   begin
      fails = 0;
      n_checks = 0;
      bus = '0;
      rst(1'b0, 1'b0);
      cyc(20);
      chk(32'({ind.led_red, ind.led_green, ind.bp_on}), 32'h7);
      cyc(1100);
      chk(32'({ind.led_red, ind.led_green, ind.laser_on}), 32'h3);
      rd(REG_CTRL, 32'h7, 32'(MODE_BLINK));
      rd(REG_IDLE, 32'hffffff, 32'(IDLE_RST));
      wr(REG_STAT, 32'hffffffff);
      rd(REG_STAT, 32'h6, 32'h2);
      rd(8'h14, 32'hffffffff, 32'h0);
      for (int t = 0; t < 8; t++)
      begin
         wr(REG_TONE, 32'(t));
         pulse(8'h80);
         cyc(4);
         chk(32'({ind.led_red, ind.bp_on, ind.bp_tone}), 32'({1'b1, t != 7, 4'(t)}));
         cyc(30);
      end
      wr(REG_CTRL, 32'h0);
      pulse(8'h80);
      cyc(4);
      chk(32'({ind.led_red, ind.bp_on}), 32'h2);
      wr(REG_CTRL, 32'h08);
      u_far.press(300);
      cyc(230);
      chk(32'({ind.bp_on, ind.bp_tone}), 32'h10);
      rd(REG_TONE, 32'h7, 32'h0);
      beeps(8500, 2);
      wr(REG_IDLE, 32'd50);
      for (int i = 0; i < 5; i++)
      begin
         wr(REG_CTRL, 32'h08 | 32'(mo[i]));
         cyc(700);
         rd(REG_STAT, 32'h38, 32'(pe[i]) << 3);
         chk(32'({ind.motor_on, pe[i] == PS_BLINK ? ind.led_green : !ind.laser_on}),
             32'({mo[i] != MODE_LMOFF, 1'b1}));
         if (mo[i] == MODE_BLINK)
         begin
            pulse(8'h80);
            rd(REG_STAT, 32'h38, 32'h0);
         end
         else
         begin
            u_far.press(300);
            cyc(1);
            chk(32'({ind.motor_on, ind.laser_on}), 32'({1'b1, mo[i] != MODE_LMOFF}));
            cyc(250);
         end
      end
      wr(REG_IDLE, 32'h0);
      pulse(8'h10);
      beeps(11100, 4);
      chk(32'(ind.laser_on), 32'h1);
      u_far.send(8'h5a, 1'b1);
      rd(REG_AUX, 32'h1ff, 32'h0);
      wr(REG_CTRL, 32'h78);
      u_far.send(8'ha5, 1'b0);
      rd(REG_AUX, 32'h1ff, 32'h1a5);
      rd(REG_AUX, 32'h1ff, 32'h0a5);
      @(posedge clk_sys) evt.prog_mode <= 1'b1;
      beeps(5500, 3);
      @(posedge clk_sys) evt.prog_mode <= 1'b0;
      beeps(5500, 3);
      pulse(8'h20);
      beeps(5500, 3);
      u_far.press(30400);
      cyc(1);
      rd(REG_STAT, 32'hf8, 32'h18);
      // Let the long release clear the debouncer before the wake press
      cyc(250);
      u_far.press(300);
      cyc(1);
      rd(REG_STAT, 32'h38, 32'h20);
      pulse(8'h08);
      beeps(3000, 1);
      pulse(8'h04);
      beeps(4000, 2);
      rst(1'b1, 1'b0);
      cyc(50);
      chk(32'({ind.bp_on, ind.bp_tone, ind.led_red, ind.led_green}), 32'h68);
      rst(1'b0, 1'b1);
      beeps(6000, 3);
      report_and_stop();
   end
endmodule // tb_sps_ctrl
`default_nettype wire
